// ===== src/pkt_dram_decoder.sv
// Purpose: request packet decoder and data packet scheduler of a packet DRAM
// Assumes: array access is external; read data arrives on READ_WORD
// Notes: link side captures packets, core side decodes on CLK
// Behaviour
// - status registers return as four-word burst at programmed read latency
// - device recognises the repeating 15-bit sync pattern on all lanes
// - reads and writes schedule a data packet a fixed time later
// - row open or close updates bank state only, no bus response
// - unused address bit positions are ignored
// - first words carry unit number, op code, bank and upper row bits
// - third word row low bits, fourth word seven-bit column
// - register read uses low four index bits, returns data packet
// - register write is four words with secondary number, index, value
// - events trigger resets, refresh, close-all, self-refresh, adjustments
// - event index in third word, tuning code and lane select last
// - adjustments applied by adjust event or within autorefresh
// - autorefresh with zero tuning code makes no adjustment
// - data packet is four or eight words, no masking
// - eight-word burst second half uses column with inverted lsb
// - after sync, flag low seventeen ticks, next flag high starts request
// - reset sets unit 255, secondary 15, minimum latencies
`timescale 1ns/1ps
module pkt_dram_decoder
  import pkt_dram_pkg::*;
(
  // core clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // link side
  input wire logic LINK_CLK,
  input wire logic FLAG,
  input wire logic [REQ_W-1:0] REQUEST_BUS,
  // data bus
  input wire logic [DQ_W-1:0] DQ_IN,
  output logic [DQ_W-1:0] DQ_OUT,
  output logic DQ_OE,
  output logic [1:0] DATA_STROBE_CLOCK_OUT,
  output logic DATA_STROBE_CLOCK_OE,
  // array side
  output logic ARRAY_READ,
  output logic ARRAY_WRITE,
  output logic [BANK_W-1:0] ARRAY_BANK,
  output logic [ROW_W-1:0] ARRAY_ROW,
  output logic [COL_W-1:0] ARRAY_COL,
  output logic [DQ_W-1:0] ARRAY_WDATA,
  output logic ARRAY_WVALID,
  input wire logic [DQ_W-1:0] READ_WORD,
  output logic ROW_OPEN,
  output logic ROW_CLOSE,
  // events and status
  output logic [6:0] EVENT_STROBE,
  output logic ADJUST_STROBE,
  output logic [TUNE_W-1:0] TUNING_CODE,
  output logic [TUNE_W-1:0] OFFSET_LANE_SELECT,
  output logic [UNIT_W-1:0] UNIT_NUMBER,
  output logic [SEC_W-1:0] SECONDARY_NUMBER,
  output logic SYNC_ACTIVE,
  output logic [LAT_W-1:0] READ_LATENCY,
  output logic [LAT_W-1:0] WRITE_LATENCY
);
  import pkt_dram_pkg::*;

  typedef enum logic [1:0] {IDLE, WAIT, XFER} phase_e;

  typedef struct packed {
    logic [2:0] link_rst;
    logic [2:0] tog_sync;
    logic [1:0] seen_sync;
    phase_e phase;
    logic is_read;
    logic burst8;
    logic [LAT_W-1:0] wait_cnt;
    logic [2:0] beat;
    logic [DQ_W-1:0] dq;
    logic oe;
    logic [1:0] dsc;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic csr_rd;
    logic [CSR_W-1:0] csr_idx;
    logic arr_rd;
    logic arr_wr;
    logic [DQ_W-1:0] wdata;
    logic wvalid;
    logic row_open;
    logic row_close;
    logic [6:0] evt;
    logic adj;
    logic [TUNE_W-1:0] tune;
    logic [TUNE_W-1:0] lane;
    logic [UNIT_W-1:0] unit;
    logic [SEC_W-1:0] sec;
    logic [LAT_W-1:0] rd_lat;
    logic [LAT_W-1:0] wr_lat;
  } core_s;

  core_s r;
  core_s next_r;
  logic [4*REQ_W-1:0] packet;
  logic packet_toggle;
  logic sync_seen;

  // link reset follows core reset through the link clock
  logic [1:0] link_rst_sync;
  always_ff @(posedge LINK_CLK) begin
    link_rst_sync <= {link_rst_sync[0], RESET_N};
  end

  req_capture u_capture (
    .link_clk(LINK_CLK),
    .link_reset_n(link_rst_sync[1]),
    .flag(FLAG),
    .request_bus(REQUEST_BUS),
    .packet(packet),
    .packet_toggle(packet_toggle),
    .sync_seen(sync_seen)
  );

  // decode of the op code, last bit of the first word and top of the second, shared by all packet types
  function automatic kind_e op_kind(input logic [OP_W-1:0] op);
    kind_e k;
    k = KIND_NONE;
    if (!op[5]) begin
      k = op[2] ? KIND_WRITE : KIND_READ;
    end else if (op[5:3] == GRP_REG_EVT) begin
      unique case (op[2:0])
        SUB_OPEN, SUB_CLOSE: k = KIND_ROW;
        SUB_CSR_WR: k = KIND_CSR_WR;
        SUB_CSR_RD0, SUB_CSR_RD1: k = KIND_CSR_RD;
        SUB_EVENT: k = KIND_EVENT;
        default: k = KIND_NONE;
      endcase
    end
    return k;
  endfunction : op_kind

  // packet fields; stable once the toggle has crossed
  logic [REQ_W-1:0] w1;
  logic [REQ_W-1:0] w2;
  logic [REQ_W-1:0] w3;
  logic [REQ_W-1:0] w4;
  logic [UNIT_W-1:0] pkt_unit;
  logic [OP_W-1:0] pkt_op;
  kind_e kind;
  logic new_pkt;
  assign w1 = packet[39:30];
  assign w2 = packet[29:20];
  assign w3 = packet[19:10];
  assign w4 = packet[9:0];
  assign pkt_unit = w1[9:1];
  assign pkt_op = {w1[0], w2[9:5]};
  assign kind = op_kind(pkt_op);
  assign new_pkt = r.tog_sync[2] ^ r.tog_sync[1];

  always_comb begin
    next_r = r;
    next_r.tog_sync = {r.tog_sync[1:0], packet_toggle};
    next_r.seen_sync = {r.seen_sync[0], sync_seen};
    next_r.row_open = 1'b0;
    next_r.row_close = 1'b0;
    next_r.evt = 7'h00;
    next_r.adj = 1'b0;
    next_r.arr_rd = 1'b0;
    next_r.arr_wr = 1'b0;
    next_r.wvalid = 1'b0;
    // only packets for this unit are acted on
    if (new_pkt && pkt_unit == r.unit && r.phase == IDLE) begin
      unique case (kind)
        KIND_READ, KIND_WRITE: begin
          next_r.phase = WAIT;
          next_r.is_read = (kind == KIND_READ);
          next_r.burst8 = pkt_op[3];
          next_r.bank = w2[4:2];
          next_r.row = {w2[1:0], w3[9:2]};
          next_r.col = w4[6:0];
          next_r.csr_rd = 1'b0;
          next_r.wait_cnt = (kind == KIND_READ) ? r.rd_lat : r.wr_lat;
          next_r.dsc = 2'b00;
        end
        KIND_ROW: begin
          next_r.bank = w2[4:2];
          next_r.row = {w2[1:0], w3[9:2]};
          next_r.row_open = (pkt_op[2:0] == SUB_OPEN);
          next_r.row_close = (pkt_op[2:0] == SUB_CLOSE);
        end
        KIND_CSR_RD: begin
          next_r.phase = WAIT;
          next_r.is_read = 1'b1;
          next_r.burst8 = 1'b0;
          next_r.csr_rd = 1'b1;
          next_r.csr_idx = {w2[1:0], w3[9:8]};
          next_r.wait_cnt = r.rd_lat;
          next_r.dsc = 2'b00;
        end
        KIND_CSR_WR: begin
          // secondary number must also match for register writes
          if (w2[4:0] == r.sec) begin
            unique case (w3[6:3])
              CSR_READ_LAT: next_r.rd_lat = (w4[3:0] < LAT_MIN) ? LAT_MIN : w4[3:0];
              CSR_WRITE_LAT: next_r.wr_lat = (w4[3:0] < LAT_MIN) ? LAT_MIN : w4[3:0];
              default: ;
            endcase
          end
        end
        KIND_EVENT: begin
          if (w2[4:0] == r.sec) begin
            unique case (w3[9:3])
              EVT_HARD_RESET, EVT_SOFT_RESET: begin
                next_r.evt[w3[5:3]] = 1'b1;
                next_r.rd_lat = LAT_MIN;
                next_r.wr_lat = LAT_MIN;
                next_r.phase = IDLE;
                if (w3[9:3] == EVT_HARD_RESET) begin
                  next_r.unit = UNIT_RESET;
                  next_r.sec = SEC_RESET;
                end
              end
              EVT_AUTOREFRESH, EVT_ADJUST: begin
                next_r.evt[w3[5:3]] = 1'b1;
                next_r.adj = (w3[9:3] == EVT_ADJUST) || (w4[9:5] != 5'h00);
                next_r.tune = w4[9:5];
                next_r.lane = w4[4:0];
              end
              EVT_CLOSE_ALL, EVT_SELF_ENTER, EVT_SELF_EXIT: next_r.evt[w3[5:3]] = 1'b1;
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end
    // data packet timing; latency counts core clocks
    unique case (r.phase)
      IDLE: begin
        next_r.oe = 1'b0;
        next_r.dsc = 2'b00;
      end
      WAIT: begin
        next_r.wait_cnt = r.wait_cnt - 4'h1;
        if (r.wait_cnt == 4'h1) begin
          next_r.phase = XFER;
          next_r.beat = 3'h0;
          next_r.arr_rd = r.is_read && !r.csr_rd;
        end
      end
      XFER: begin
        next_r.beat = r.beat + 3'h1;
        next_r.oe = r.is_read;
        next_r.dsc = r.is_read ? {r.beat[0], r.beat[0]} : 2'b00;
        if (r.is_read) begin
          // status reads return the index and both latency registers padded to a word
          next_r.dq = r.csr_rd ? DQ_W'({r.csr_idx, r.rd_lat, r.wr_lat}) : READ_WORD;
        end else begin
          next_r.wdata = DQ_IN;
          next_r.wvalid = 1'b1;
          next_r.arr_wr = 1'b1;
        end
        if (r.beat == {1'b0, BURST4_WORDS}) begin
          next_r.col = r.col ^ 7'h01;
          next_r.arr_rd = r.is_read && !r.csr_rd && r.burst8;
        end
        if (r.beat == (r.burst8 ? 3'h7 : {1'b0, BURST4_WORDS})) begin
          next_r.phase = IDLE;
        end
      end
      default: next_r.phase = IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      r <= '0;
      r.phase <= IDLE;
      r.unit <= UNIT_RESET;
      r.sec <= SEC_RESET;
      r.rd_lat <= LAT_MIN;
      r.wr_lat <= LAT_MIN;
    end else begin
      r <= next_r;
    end
  end

  assign DQ_OUT = r.dq;
  assign DQ_OE = r.oe;
  assign DATA_STROBE_CLOCK_OUT = r.dsc;
  assign DATA_STROBE_CLOCK_OE = r.oe;
  assign ARRAY_READ = r.arr_rd;
  assign ARRAY_WRITE = r.arr_wr;
  assign ARRAY_BANK = r.bank;
  assign ARRAY_ROW = r.row;
  assign ARRAY_COL = r.col;
  assign ARRAY_WDATA = r.wdata;
  assign ARRAY_WVALID = r.wvalid;
  assign ROW_OPEN = r.row_open;
  assign ROW_CLOSE = r.row_close;
  assign EVENT_STROBE = r.evt;
  assign ADJUST_STROBE = r.adj;
  assign TUNING_CODE = r.tune;
  assign OFFSET_LANE_SELECT = r.lane;
  assign UNIT_NUMBER = r.unit;
  assign SECONDARY_NUMBER = r.sec;
  assign SYNC_ACTIVE = r.seen_sync[1];
  assign READ_LATENCY = r.rd_lat;
  assign WRITE_LATENCY = r.wr_lat;
endmodule : pkt_dram_decoder

// ===== src/pkt_dram_pkg.sv
// Purpose: shared constants and types for the packet request decoder
// Assumes: 10-bit request bus, 18-bit data bus, 4-word request packets
// Notes: op-code values follow the command table layout
package pkt_dram_pkg;
  localparam int REQ_W = 10;
  localparam int DQ_W = 18;
  localparam int UNIT_W = 9;
  localparam int SEC_W = 5;
  localparam int OP_W = 6;
  localparam int BANK_W = 3;
  localparam int ROW_W = 10;
  localparam int COL_W = 7;
  localparam int CSR_W = 4;
  localparam int EVT_W = 7;
  localparam int TUNE_W = 5;
  localparam int LAT_W = 4;
  localparam int SYNC_LEN = 15;
  localparam logic [14:0] SYNC_EVEN = 15'h7ac8;
  localparam logic [14:0] SYNC_ODD = 15'h0537;
  localparam logic [4:0] QUIET_TICKS = 5'h10;
  localparam logic [UNIT_W-1:0] UNIT_RESET = 9'h0ff;
  localparam logic [SEC_W-1:0] SEC_RESET = 5'h0f;
  localparam logic [LAT_W-1:0] LAT_MIN = 4'h2;
  localparam logic [2:0] GRP_REG_EVT = 3'h4;
  localparam logic [2:0] SUB_OPEN = 3'h1;
  localparam logic [2:0] SUB_CLOSE = 3'h2;
  localparam logic [2:0] SUB_CSR_WR = 3'h3;
  localparam logic [2:0] SUB_CSR_RD0 = 3'h4;
  localparam logic [2:0] SUB_CSR_RD1 = 3'h5;
  localparam logic [2:0] SUB_EVENT = 3'h7;
  localparam logic [CSR_W-1:0] CSR_READ_LAT = 4'h0;
  localparam logic [CSR_W-1:0] CSR_WRITE_LAT = 4'h1;
  localparam logic [EVT_W-1:0] EVT_HARD_RESET = 7'h00;
  localparam logic [EVT_W-1:0] EVT_SOFT_RESET = 7'h01;
  localparam logic [EVT_W-1:0] EVT_AUTOREFRESH = 7'h02;
  localparam logic [EVT_W-1:0] EVT_CLOSE_ALL = 7'h03;
  localparam logic [EVT_W-1:0] EVT_SELF_ENTER = 7'h04;
  localparam logic [EVT_W-1:0] EVT_SELF_EXIT = 7'h05;
  localparam logic [EVT_W-1:0] EVT_ADJUST = 7'h06;
  localparam logic [1:0] BURST4_WORDS = 2'h3;
  localparam int REQ_WORDS = 4;
  typedef enum logic [2:0] {KIND_NONE, KIND_READ, KIND_WRITE, KIND_ROW, KIND_CSR_RD, KIND_CSR_WR,
                            KIND_EVENT} kind_e;
endpackage : pkt_dram_pkg

// ===== src/req_capture.sv
// Purpose: link-clock side: sync pattern check and request word capture
// Assumes: link clock runs while packets are sent
// Notes: a full packet is handed over as a word bundle plus a toggle
`timescale 1ns/1ps
module req_capture
  import pkt_dram_pkg::*;
(
  // link
  input wire logic link_clk,
  input wire logic link_reset_n,
  input wire logic flag,
  input wire logic [REQ_W-1:0] request_bus,
  // handover
  output logic [4*REQ_W-1:0] packet,
  output logic packet_toggle,
  output logic sync_seen
);
  import pkt_dram_pkg::*;
  typedef struct packed {
    logic [1:0] word_cnt;
    logic busy;
    logic [4*REQ_W-1:0] shift;
    logic [4*REQ_W-1:0] packet;
    logic toggle;
    logic [3:0] sync_pos;
    logic sync_mode;
    logic [4:0] quiet;
  } cap_s;
  cap_s r;
  cap_s next_r;
  logic [14:0] rot_even;
  logic [14:0] rot_odd;
  logic lanes_ok;
  always_comb begin
    next_r = r;
    rot_even = SYNC_EVEN << r.sync_pos;
    rot_odd = SYNC_ODD << r.sync_pos;
    lanes_ok = (flag == rot_even[14]) && (request_bus == {5{rot_odd[14], rot_even[14]}});
    // sync pattern tracking; flag highs inside it are not requests
    if (lanes_ok && (r.sync_mode || flag)) begin
      next_r.sync_mode = 1'b1;
      next_r.sync_pos = (r.sync_pos == 4'(SYNC_LEN - 1)) ? 4'h0 : r.sync_pos + 4'h1;
    end else if (r.sync_mode) begin
      next_r.sync_pos = 4'h0;
    end
    if (r.sync_mode) begin
      // the flag high that opened sync is no packet start
      next_r.busy = 1'b0;
      // leave sync only after a long flag-low gap
      next_r.quiet = flag ? 5'h00 : ((r.quiet == QUIET_TICKS) ? r.quiet : r.quiet + 5'h01);
      if (r.quiet == QUIET_TICKS && !flag) begin
        next_r.sync_mode = 1'b0;
        next_r.sync_pos = 4'h0;
      end
    end else if (!r.busy && flag) begin
      next_r.busy = 1'b1;
      next_r.word_cnt = 2'h1;
      next_r.shift = {request_bus, 30'h0};
    end else if (r.busy) begin
      next_r.shift[(3-r.word_cnt)*REQ_W +: REQ_W] = request_bus;
      next_r.word_cnt = r.word_cnt + 2'h1;
      if (r.word_cnt == 2'(REQ_WORDS - 1)) begin
        next_r.busy = 1'b0;
        next_r.packet = {r.shift[4*REQ_W-1:REQ_W], request_bus};
        next_r.toggle = ~r.toggle;
      end
    end
  end
  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign packet = r.packet;
  assign packet_toggle = r.toggle;
  assign sync_seen = r.sync_mode;
endmodule : req_capture

// ===== tb/ctrl_model.sv
// Purpose: memory controller side of the request channel
// Assumes: link clock runs free
// Notes: words queue up and leave one per link tick
`timescale 1ns/1ps
module ctrl_model (
  // clocks
  input wire logic LINK_CLK,
  input wire logic CLK,
  // request and write data
  output logic FLAG,
  output logic [9:0] REQUEST_BUS,
  output logic [17:0] DQ_IN
);
  localparam logic [14:0] pat = 15'b111101011001000;
  logic [10:0] q[$];
  initial begin
    FLAG = 0;
    REQUEST_BUS = 0;
    DQ_IN = 0;
  end
  // running count doubles as write data
  always @(negedge CLK) DQ_IN <= DQ_IN + 18'h1;
  // idle bus inverts so a stale word never looks valid
  always @(negedge LINK_CLK) begin
    if (q.size() != 0) {FLAG, REQUEST_BUS} <= q.pop_front();
    else {FLAG, REQUEST_BUS} <= {1'b0, ~REQUEST_BUS};
  end
  task automatic send(input logic [39:0] p);
    q.push_back({1'b1, p[39:30]});
    q.push_back({1'b0, p[29:20]});
    q.push_back({1'b0, p[19:10]});
    q.push_back({1'b0, p[9:0]});
    wait (q.size() == 0);
    repeat (2) @(posedge LINK_CLK);
  endtask : send
  task automatic sync(input int reps);
    for (int r = 0; r < reps; r++)
      for (int i = 14; i >= 0; i--) q.push_back({pat[i], {5{~pat[i], pat[i]}}});
    wait (q.size() == 0);
  endtask : sync
endmodule : ctrl_model

// ===== tb/pkt_dram_decoder_asserts.sv
// Purpose: port checks of the request decoder
// Assumes: core clock domain only
// Notes: bound to every decoder instance
`timescale 1ns/1ps
module pkt_dram_decoder_chk (
  // core
  input wire logic CLK,
  input wire logic RESET_N,
  // data bus
  input wire logic DQ_OE,
  input wire logic [1:0] DATA_STROBE_CLOCK_OUT,
  input wire logic DATA_STROBE_CLOCK_OE,
  // array and events
  input wire logic ARRAY_READ,
  input wire logic ARRAY_WRITE,
  input wire logic ARRAY_WVALID,
  input wire logic ROW_OPEN,
  input wire logic ROW_CLOSE,
  input wire logic [6:0] EVENT_STROBE,
  input wire logic ADJUST_STROBE,
  // status
  input wire logic [8:0] UNIT_NUMBER,
  input wire logic [4:0] SECONDARY_NUMBER,
  input wire logic [3:0] READ_LATENCY,
  input wire logic [3:0] WRITE_LATENCY
);
  import pkt_dram_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  AST_STROBE_OE: assert property (DATA_STROBE_CLOCK_OE == DQ_OE)
    else $error("strobe enable differs");
  AST_RESET_VALUES: assert property ($rose(RESET_N) |-> UNIT_NUMBER == 9'h0ff &&
    SECONDARY_NUMBER == 5'h0f && READ_LATENCY == LAT_MIN && WRITE_LATENCY == LAT_MIN)
    else $error("bad reset values");
  AST_ROW_QUIET: assert property (ROW_OPEN || ROW_CLOSE |=> !DQ_OE [*4])
    else $error("row op drove data");
  AST_ROW_PULSE: assert property (ROW_OPEN |=> !ROW_OPEN)
    else $error("row open too long");
  AST_BURST_LEN: assert property ($rose(DQ_OE) |-> DQ_OE [*4] ##1 (!DQ_OE or (DQ_OE [*4] ##1 !DQ_OE)))
    else $error("bad burst length");
  AST_READ_FOLLOWS: assert property (ARRAY_READ |-> ##[1:2] DQ_OE)
    else $error("read beat missing");
  AST_STROBE_TOGGLE: assert property (DQ_OE && $past(DQ_OE) |->
    DATA_STROBE_CLOCK_OUT != $past(DATA_STROBE_CLOCK_OUT))
    else $error("strobe did not toggle");
  AST_WRITE_NO_DRIVE: assert property (ARRAY_WRITE |-> ARRAY_WVALID && !DQ_OE)
    else $error("write beat driven");
  AST_EVENT_ONEHOT: assert property (EVENT_STROBE != 0 |-> $onehot(EVENT_STROBE) ##1 EVENT_STROBE == 0)
    else $error("bad event strobe");
  AST_ADJ_PULSE: assert property (ADJUST_STROBE |=> !ADJUST_STROBE)
    else $error("adjust too long");
  AST_LAT_FLOOR: assert property (READ_LATENCY >= LAT_MIN && WRITE_LATENCY >= LAT_MIN)
    else $error("latency under minimum");
endmodule : pkt_dram_decoder_chk
bind pkt_dram_decoder pkt_dram_decoder_chk chk_inst (.CLK, .RESET_N, .DQ_OE, .DATA_STROBE_CLOCK_OUT,
  .DATA_STROBE_CLOCK_OE, .ARRAY_READ, .ARRAY_WRITE, .ARRAY_WVALID, .ROW_OPEN, .ROW_CLOSE,
  .EVENT_STROBE, .ADJUST_STROBE, .UNIT_NUMBER, .SECONDARY_NUMBER, .READ_LATENCY, .WRITE_LATENCY);

// ===== tb/testbench.sv
// Purpose: self-checking bench of the request decoder
// Assumes: controller model drives link and write data
// Notes: responses counted per packet
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import pkt_dram_pkg::*;
  logic CLK = 0, LINK_CLK = 0, RESET_N = 0, FLAG, DQ_OE, DATA_STROBE_CLOCK_OE, SYNC_ACTIVE;
  logic ARRAY_READ, ARRAY_WRITE, ARRAY_WVALID, ROW_OPEN, ROW_CLOSE, ADJUST_STROBE;
  logic [REQ_W-1:0] REQUEST_BUS;
  logic [DQ_W-1:0] DQ_IN, DQ_OUT, ARRAY_WDATA, rw_q;
  logic [DQ_W-1:0] READ_WORD = 0;
  // status reads return latency words, not array words
  logic st_on = 0;
  logic [DQ_W-1:0] st_exp = 0;
  logic [1:0] DATA_STROBE_CLOCK_OUT;
  logic [BANK_W-1:0] ARRAY_BANK, bank, seen_bank;
  logic [ROW_W-1:0] ARRAY_ROW, row, seen_row;
  logic [COL_W-1:0] ARRAY_COL, col;
  logic [6:0] EVENT_STROBE, ev_or;
  logic [TUNE_W-1:0] TUNING_CODE, OFFSET_LANE_SELECT, tn;
  logic [UNIT_W-1:0] UNIT_NUMBER;
  logic [SEC_W-1:0] SECONDARY_NUMBER;
  logic [LAT_W-1:0] READ_LATENCY, WRITE_LATENCY;
  int failures = 0, n_checks = 0, cyc = 0, t0, t_oe, n_rd, n_oe, n_wr, n_open, n_close, n_adj, d2;
  logic [COL_W-1:0] colq[$];
  logic [DQ_W-1:0] wq[$];
  localparam logic [UNIT_W-1:0] U = 9'h0ff;
  always #50 CLK = ~CLK;
  always #24 LINK_CLK = ~LINK_CLK;
  pkt_dram_decoder pkt_dram_decoder_inst (.CLK, .RESET_N, .LINK_CLK, .FLAG, .REQUEST_BUS, .DQ_IN, .DQ_OUT,
    .DQ_OE, .DATA_STROBE_CLOCK_OUT, .DATA_STROBE_CLOCK_OE, .ARRAY_READ, .ARRAY_WRITE, .ARRAY_BANK,
    .ARRAY_ROW, .ARRAY_COL, .ARRAY_WDATA, .ARRAY_WVALID, .READ_WORD, .ROW_OPEN, .ROW_CLOSE, .EVENT_STROBE,
    .ADJUST_STROBE, .TUNING_CODE, .OFFSET_LANE_SELECT, .UNIT_NUMBER, .SECONDARY_NUMBER, .SYNC_ACTIVE,
    .READ_LATENCY, .WRITE_LATENCY);
  ctrl_model ctrl_model_inst (.LINK_CLK, .CLK, .FLAG, .REQUEST_BUS, .DQ_IN);
  always @(negedge CLK) READ_WORD <= DQ_W'($urandom);
  always @(posedge CLK) begin
    cyc++;
    if (DQ_OE) begin
      `CHK("read word", st_on ? st_exp : rw_q, DQ_OUT)
      if (n_oe == 0) t_oe = cyc;
      n_oe++;
    end
    if (ARRAY_READ) begin
      colq.push_back(ARRAY_COL);
      seen_bank = ARRAY_BANK;
      seen_row = ARRAY_ROW;
    end
    if (ARRAY_WRITE) wq.push_back(ARRAY_WDATA);
    n_rd += ARRAY_READ;
    n_wr += ARRAY_WRITE;
    n_open += ROW_OPEN;
    n_close += ROW_CLOSE;
    n_adj += ADJUST_STROBE;
    ev_or |= EVENT_STROBE;
    rw_q = READ_WORD;
  end
  task automatic run(input logic [39:0] p);
    {n_rd, n_oe, n_wr, n_open, n_close, n_adj} = '0;
    ev_or = '0;
    colq.delete();
    wq.delete();
    ctrl_model_inst.send(p);
    t0 = cyc;
    repeat (40) @(negedge CLK);
  endtask : run
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // 24 packets of about 45 cycles, so 2 ms is ample
  initial begin
    #2000000;
    failures++;
    final_report();
  end
  initial begin
    void'($urandom(32'h0e68f1ad));
    repeat (5) @(negedge CLK);
    RESET_N = 1;
    repeat (4) @(negedge CLK);
    `CHK("unit", 9'h0ff, UNIT_NUMBER)
    `CHK("secondary", 5'h0f, SECONDARY_NUMBER)
    `CHK("write latency", LAT_MIN, WRITE_LATENCY)
    ctrl_model_inst.sync(3);
    repeat (2) @(negedge CLK);
    `CHK("sync seen", 1'b1, SYNC_ACTIVE)
    repeat (30) @(negedge CLK);
    `CHK("sync left", 1'b0, SYNC_ACTIVE)
    for (int i = 0; i < 4; i++) begin
      bank = 3'($urandom);
      row = 10'($urandom);
      col = 7'($urandom);
      run({U, 1'b0, i[1], i[0], 3'b000, bank, row, 5'($urandom), col});
      `CHK("reads", i[0] ? 2 : 1, n_rd)
      `CHK("beats", i[0] ? 8 : 4, n_oe)
      `CHK("bank", bank, seen_bank)
      `CHK("row", row, seen_row)
      `CHK("column", col, colq[0])
      if (i[0]) `CHK("wrapped column", col ^ 7'h01, colq[1])
    end
    for (int i = 0; i < 4; i++) begin
      run({U, 1'b0, i[1], i[0], 3'b100, 3'($urandom), 10'($urandom), 5'h00, 7'($urandom)});
      `CHK("write beats", i[0] ? 8 : 4, n_wr)
      `CHK("no drive", 0, n_oe)
      `CHK("count run", n_wr - 1, int'(wq[$] - wq[0]))
    end
    run({9'h0aa, 6'h00, 25'($urandom)});
    `CHK("other unit", 0, n_rd + n_oe)
    run({U, 6'b100001, 3'($urandom), 10'($urandom), 12'h000});
    `CHK("open", 1, n_open)
    `CHK("open quiet", 0, n_oe + n_rd)
    run({U, 6'b100010, 25'h0});
    `CHK("close", 1, n_close)
    // first status read doubles as the latency probe
    st_exp = DQ_W'({CSR_READ_LAT, LAT_MIN, LAT_MIN});
    st_on = 1'b1;
    run({U, 6'b100100, 3'b111, CSR_READ_LAT, 18'($urandom)});
    `CHK("status beats", 4, n_oe)
    st_on = 1'b0;
    d2 = t_oe - t0;
    run({U, 6'b100011, 5'h03, 3'b000, 4'h0, 3'b000, 10'h005});
    `CHK("foreign secondary", LAT_MIN, READ_LATENCY)
    run({U, 6'b100011, 5'h0f, 3'b000, 4'h0, 3'b000, 6'($urandom), 4'h5});
    `CHK("read latency set", 4'h5, READ_LATENCY)
    st_exp = DQ_W'({CSR_READ_LAT, 4'h5, LAT_MIN});
    st_on = 1'b1;
    run({U, 6'b100101, 7'h00, 18'h0});
    st_on = 1'b0;
    // crossing jitter allows one cycle either way
    `CHK("latency moved", 1'b1, (t_oe - t0 - d2) inside {[2:4]})
    run({U, 6'b100011, 5'h0f, 3'b000, 4'h1, 3'b000, 10'h001});
    `CHK("write latency floor", 4'h2, WRITE_LATENCY)
    for (int e = 0; e < 8; e++) begin
      tn = (e == 6) ? 5'h0b : (e == 7) ? 5'h13 : 5'h00;
      run({U, 6'b100111, 5'h0f, (e == 7) ? 7'h02 : 7'(e), 3'b000, tn, 5'h1f});
      `CHK("event", 7'h01 << ((e == 7) ? 2 : e), ev_or)
      `CHK("adjust", (e >= 6) ? 1 : 0, n_adj)
    end
    `CHK("tuning", 5'h13, TUNING_CODE)
    `CHK("lane", 5'h1f, OFFSET_LANE_SELECT)
    final_report();
  end
endmodule : testbench
